// ===== inc/eeprom_bus_pkg.sv
// constants and state encoding shared by the serial memory bus slave
//==========================================================
// Function
// - selected only when all three strap levels equal the control byte select bits
// - unconnected strap inputs read low through their pad pull-downs
// - data line is open drain: pulled low or released, never driven high
// - data changes only while clock low; changes at clock high are conditions
// - write-protect high blocks every array write; reads still served
// - data falling while clock high is a start; every command begins so
// - data rising while clock high is a stop; every operation ends so
// - one bit per clock pulse, stable across the whole high phase
// - receiver acknowledges each byte holding data low on the ninth clock
// - no acknowledge at all while the internal write cycle runs
// - master nack ends a read; device releases data for the stop
// - control byte is type code, three select bits, direction; ack only on match
// - direction bit one means read, zero means write
// - two address bytes follow, high first; only low fifteen bits used
// - control, address high, address low, data, each acked; stop starts the write
// - protected write still acked, but no cycle, no change, ready at once
// - after a byte write the address counter points past the written byte
// - address counter wraps inside this array, never into another device
// - self-timed write cycle ends within five milliseconds
// - write-protect level sampled at the stop of each write command
`default_nettype none
package eeprom_bus_pkg;
	localparam int CLK_MHZ = 100;
	localparam int WRITE_TIME_US = 5000;
	localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
	localparam int ADDR_W = 15;
	localparam logic [14:0] ADDR_RESET = 15'h0000;
	localparam logic [14:0] ADDR_LAST = 15'h7fff;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [5:0] PIN_RESET = 6'h03;
	localparam logic [2:0] REQ_RESET = 3'h0;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CTRL = 3'h1,
		ST_ADDR_HI = 3'h3,
		ST_ADDR_LO = 3'h2,
		ST_WDATA = 3'h6,
		ST_RDATA = 3'h7,
		ST_SKIP = 3'h5
	} bus_state_t;
endpackage : eeprom_bus_pkg
`default_nettype wire

// ===== logic/eeprom_bus_slave.sv
// two-wire bus slave front end of the serial nonvolatile memory
`default_nettype none
module eeprom_bus_slave #(
	parameter logic [3:0] DEV_CODE = 4'h5, // arbitrary value
	parameter int WRITE_CYCLES = eeprom_bus_pkg::WRITE_CYCLES
) (
	// core clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// bus pins
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// protect and strap pins
	input wire logic i_wp,
	input wire logic i_chip_select_strap_0,
	input wire logic i_chip_select_strap_1,
	input wire logic i_chip_select_strap_2,
	// array read port
	output logic [eeprom_bus_pkg::ADDR_W-1:0] o_rd_addr,
	input wire logic [7:0] i_rd_data,
	// status
	output logic o_busy,
	// array write port
	input wire logic i_array_clk,
	input wire logic i_array_rstn,
	output logic o_arr_we,
	output logic [eeprom_bus_pkg::ADDR_W-1:0] o_arr_addr,
	output logic [7:0] o_arr_data
);
	localparam int TW = $clog2(WRITE_CYCLES + 1);
	localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYCLES - 1);
	localparam logic [TW-1:0] TIMER_ZERO = '0;

	//==========================================================
	// pin synchronisers
	logic [5:0] pin_raw;
	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	logic scl_q, sda_q, scl_s, sda_s, wp_s;
	logic [2:0] strap;

	// pad pull-downs make a floating strap or protect pin arrive as low
	assign pin_raw = {i_wp, i_chip_select_strap_2, i_chip_select_strap_1,
		i_chip_select_strap_0, i_sda, i_scl};

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			pin_s1 <= eeprom_bus_pkg::PIN_RESET;
			pin_s2 <= eeprom_bus_pkg::PIN_RESET;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			scl_q <= pin_s2[0];
			sda_q <= pin_s2[1];
		end
	end

	assign scl_s = pin_s2[0];
	assign sda_s = pin_s2[1];
	assign strap = pin_s2[4:2];
	assign wp_s = pin_s2[5];

	//==========================================================
	// bus conditions and edges
	logic start_c, stop_c, scl_rise, scl_fall;

	assign start_c = scl_s & scl_q & sda_q & ~sda_s;
	assign stop_c = scl_s & scl_q & ~sda_q & sda_s;
	assign scl_rise = scl_s & ~scl_q;
	assign scl_fall = ~scl_s & scl_q;

	//==========================================================
	// state and datapath registers
	eeprom_bus_pkg::bus_state_t state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shreg, tx, wr_data;
	logic [6:0] addr_hi;
	logic [eeprom_bus_pkg::ADDR_W-1:0] wr_addr;
	logic have_data, master_ack, next_oe, req_tog;
	logic [TW-1:0] timer;

	//==========================================================
	// decode
	logic byte_done, ack_done, ctrl_hit, ctrl_take, rx_ack, tx_load;
	logic tx_shift, read_end, commit_ok, commit_go, in_rx;

	assign byte_done = scl_fall & (bit_cnt == eeprom_bus_pkg::BIT_LAST);
	assign ack_done = scl_fall & (bit_cnt == eeprom_bus_pkg::BIT_ACK);
	assign ctrl_hit = (shreg[7:4] == DEV_CODE) & (shreg[3:1] == strap);
	assign ctrl_take = (state == eeprom_bus_pkg::ST_CTRL) & ctrl_hit & ~o_busy;
	assign in_rx = (state == eeprom_bus_pkg::ST_ADDR_HI) |
		(state == eeprom_bus_pkg::ST_ADDR_LO) |
		(state == eeprom_bus_pkg::ST_WDATA);
	assign rx_ack = ctrl_take | in_rx;
	assign tx_load = ack_done & (state == eeprom_bus_pkg::ST_RDATA) & master_ack;
	assign read_end = ack_done & (state == eeprom_bus_pkg::ST_RDATA) & ~master_ack;
	assign tx_shift = scl_fall & (state == eeprom_bus_pkg::ST_RDATA) &
		(bit_cnt < eeprom_bus_pkg::BIT_LAST);
	assign commit_ok = (state == eeprom_bus_pkg::ST_WDATA) & have_data &
		(bit_cnt == eeprom_bus_pkg::BIT_FIRST);
	// protect level is taken at the stop itself; later changes cannot matter
	assign commit_go = stop_c & commit_ok & ~wp_s;

	//==========================================================
	// next state
	always_comb begin
		next_state = state;
		case (state)
			eeprom_bus_pkg::ST_CTRL: begin
				if (byte_done) begin
					if (!ctrl_take) begin
						next_state = eeprom_bus_pkg::ST_SKIP;
					end else if (shreg[0]) begin
						next_state = eeprom_bus_pkg::ST_RDATA;
					end else begin
						next_state = eeprom_bus_pkg::ST_ADDR_HI;
					end
				end
			end
			eeprom_bus_pkg::ST_ADDR_HI: begin
				if (byte_done) begin
					next_state = eeprom_bus_pkg::ST_ADDR_LO;
				end
			end
			eeprom_bus_pkg::ST_ADDR_LO: begin
				if (byte_done) begin
					next_state = eeprom_bus_pkg::ST_WDATA;
				end
			end
			eeprom_bus_pkg::ST_RDATA: begin
				if (read_end) begin
					next_state = eeprom_bus_pkg::ST_SKIP;
				end
			end
			eeprom_bus_pkg::ST_WDATA,
			eeprom_bus_pkg::ST_IDLE,
			eeprom_bus_pkg::ST_SKIP: begin
				next_state = state;
			end
			default: begin
				next_state = eeprom_bus_pkg::ST_IDLE;
			end
		endcase
		if (start_c) begin
			next_state = eeprom_bus_pkg::ST_CTRL;
		end else if (stop_c) begin
			next_state = eeprom_bus_pkg::ST_IDLE;
		end
	end

	//==========================================================
	// bit counter and line drive
	always_comb begin
		next_bit_cnt = bit_cnt;
		if (start_c) begin
			// the clock fall that follows a start closes no bit
			next_bit_cnt = eeprom_bus_pkg::BIT_ACK;
		end else if (ack_done) begin
			next_bit_cnt = eeprom_bus_pkg::BIT_FIRST;
		end else if (scl_fall) begin
			next_bit_cnt = bit_cnt + 4'h1;
		end
	end

	// line only ever moves on a clock fall or a condition
	always_comb begin
		next_oe = o_sda_oe;
		if (start_c || stop_c) begin
			next_oe = 1'b0;
		end else if (byte_done) begin
			next_oe = rx_ack;
		end else if (ack_done) begin
			next_oe = tx_load & ~i_rd_data[7];
		end else if (tx_shift) begin
			next_oe = ~tx[7];
		end
	end

	//==========================================================
	// protocol registers
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state <= eeprom_bus_pkg::ST_IDLE;
			bit_cnt <= eeprom_bus_pkg::BIT_FIRST;
			o_sda_oe <= 1'b0;
			o_sda_out <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			o_sda_oe <= next_oe;
			o_sda_out <= 1'b0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			shreg <= eeprom_bus_pkg::BYTE_RESET;
			tx <= eeprom_bus_pkg::BYTE_RESET;
			master_ack <= 1'b0;
		end else begin
			if (scl_rise && bit_cnt < eeprom_bus_pkg::BIT_ACK) begin
				shreg <= {shreg[6:0], sda_s};
			end
			if (scl_rise && bit_cnt == eeprom_bus_pkg::BIT_ACK) begin
				master_ack <= ~sda_s;
			end
			if (tx_load) begin
				tx <= {i_rd_data[6:0], 1'b0};
			end else if (tx_shift) begin
				tx <= {tx[6:0], 1'b0};
			end
		end
	end

	//==========================================================
	// address counter and write capture
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			addr_hi <= 7'h00;
			o_rd_addr <= eeprom_bus_pkg::ADDR_RESET;
			wr_addr <= eeprom_bus_pkg::ADDR_RESET;
			wr_data <= eeprom_bus_pkg::BYTE_RESET;
			have_data <= 1'b0;
		end else begin
			if (byte_done && state == eeprom_bus_pkg::ST_ADDR_HI) begin
				addr_hi <= shreg[6:0];
			end
			if (byte_done && state == eeprom_bus_pkg::ST_ADDR_LO) begin
				o_rd_addr <= {addr_hi, shreg};
			end else if (tx_load) begin
				o_rd_addr <= o_rd_addr + 15'h0001;
			end else if (commit_go) begin
				o_rd_addr <= wr_addr + 15'h0001;
			end
			if (byte_done && state == eeprom_bus_pkg::ST_WDATA) begin
				wr_addr <= o_rd_addr;
				wr_data <= shreg;
			end
			if (start_c || stop_c) begin
				have_data <= 1'b0;
			end else if (byte_done && state == eeprom_bus_pkg::ST_WDATA) begin
				have_data <= 1'b1;
			end
		end
	end

	//==========================================================
	// self-timed write cycle
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_busy <= 1'b0;
			timer <= TIMER_ZERO;
			req_tog <= 1'b0;
		end else begin
			if (commit_go) begin
				o_busy <= 1'b1;
				timer <= TIMER_LOAD;
				req_tog <= ~req_tog;
			end else if (o_busy && timer == TIMER_ZERO) begin
				o_busy <= 1'b0;
			end else if (o_busy) begin
				timer <= timer - TW'(1);
			end
		end
	end

	//==========================================================
	// array clock side
	// address and data stay frozen while busy, so the toggle is enough
	logic [2:0] req_sync;
	logic arr_edge;

	assign arr_edge = req_sync[2] ^ req_sync[1];

	always_ff @(posedge i_array_clk) begin
		if (!i_array_rstn) begin
			req_sync <= eeprom_bus_pkg::REQ_RESET;
			o_arr_we <= 1'b0;
			o_arr_addr <= eeprom_bus_pkg::ADDR_RESET;
			o_arr_data <= eeprom_bus_pkg::BYTE_RESET;
		end else begin
			req_sync <= {req_sync[1:0], req_tog};
			o_arr_we <= arr_edge;
			if (arr_edge) begin
				o_arr_addr <= wr_addr;
				o_arr_data <= wr_data;
			end
		end
	end

	//==========================================================
	// checks
	int busy_len;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			busy_len <= 0;
		end else if (o_busy) begin
			busy_len <= busy_len + 1;
		end else begin
			busy_len <= 0;
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	property p_oe_on_fall;
		$changed(o_sda_oe) |-> $past(scl_fall) || $past(start_c) || $past(stop_c);
	endproperty
	a_oe_on_fall: assert property (p_oe_on_fall) else $error("line moved off a fall");
	property p_busy_nack;
		(state == eeprom_bus_pkg::ST_CTRL) && byte_done && o_busy
			|=> !o_sda_oe && state == eeprom_bus_pkg::ST_SKIP;
	endproperty
	a_busy_nack: assert property (p_busy_nack) else $error("acked while busy");
	property p_sel_ack;
		(state == eeprom_bus_pkg::ST_CTRL) && byte_done && ctrl_hit && !o_busy |=> o_sda_oe;
	endproperty
	a_sel_ack: assert property (p_sel_ack) else $error("control byte not acked");
	property p_dir;
		ctrl_take && byte_done && shreg[0] |=> state == eeprom_bus_pkg::ST_RDATA;
	endproperty
	a_dir: assert property (p_dir) else $error("read direction not taken");
	property p_start;
		start_c |=> state == eeprom_bus_pkg::ST_CTRL &&
			bit_cnt == eeprom_bus_pkg::BIT_ACK && !o_sda_oe;
	endproperty
	a_start: assert property (p_start) else $error("start did not restart byte");
	property p_stop;
		stop_c |=> state == eeprom_bus_pkg::ST_IDLE && !o_sda_oe;
	endproperty
	a_stop: assert property (p_stop) else $error("stop did not return to idle");
	property p_wp_block;
		stop_c && commit_ok && wp_s |=> !o_busy ##1 !o_busy;
	endproperty
	a_wp_block: assert property (p_wp_block) else $error("protected write began");
	property p_commit;
		commit_go |=> o_busy && o_rd_addr == $past(wr_addr) + 15'h0001;
	endproperty
	a_commit: assert property (p_commit) else $error("write commit wrong");
	property p_nack_end;
		read_end |=> !o_sda_oe && state == eeprom_bus_pkg::ST_SKIP;
	endproperty
	a_nack_end: assert property (p_nack_end) else $error("line held after nack");
	property p_wrap;
		tx_load && o_rd_addr == eeprom_bus_pkg::ADDR_LAST
			|=> o_rd_addr == eeprom_bus_pkg::ADDR_RESET;
	endproperty
	a_wrap: assert property (p_wrap) else $error("address did not wrap");
	property p_busy_len;
		busy_len <= WRITE_CYCLES;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle too long");

	c_write: cover property (commit_go);
	c_read: cover property (tx_load);
	c_busy_nack: cover property (ctrl_hit && byte_done && o_busy);
	c_wp_block: cover property (stop_c && commit_ok && wp_s);
endmodule : eeprom_bus_slave
`default_nettype wire

// ===== verification/bus_master_model.sv
// two-wire bus master model that makes the clock and the bus conditions
`default_nettype none
module bus_master_model (
	// core clock
	input wire logic i_clk,
	// bus
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF = 12;
	//==========================================================
	// phases
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic hold(input logic scl, input logic low);
		@(posedge i_clk);
		o_scl <= scl;
		o_sda_low <= low;
		repeat (HALF) @(posedge i_clk);
	endtask : hold
	//==========================================================
	// conditions and bits
	task automatic start();
		hold(1'b0, o_sda_low);
		hold(1'b0, 1'b0);
		hold(1'b1, 1'b0);
		hold(1'b1, 1'b1);
	endtask : start
	task automatic stop();
		hold(1'b0, o_sda_low);
		hold(1'b0, 1'b1);
		hold(1'b1, 1'b1);
		hold(1'b1, 1'b0);
	endtask : stop
	// data moves only while the clock is low, sampled at the end of the high phase
	task automatic bit_io(input logic b, output logic seen);
		hold(1'b0, o_sda_low);
		hold(1'b0, !b);
		hold(1'b1, !b);
		seen = i_sda;
	endtask : bit_io
	// ninth bit: releases for a device ack, or acks itself when reading
	task automatic xfer(input logic [7:0] b, input logic ack_in, output logic [7:0] got,
			output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], got[i]);
		end
		bit_io(ack_in, ack);
	endtask : xfer
endmodule : bus_master_model
`default_nettype wire

// ===== verification/testbench.sv
// self-checking bench of the serial memory bus slave
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0] CODE = 4'h5; // arbitrary value
	localparam int WCYC = 2000;
	localparam int LIMIT = 90000;
	logic clk = 1'b0, rstn = 1'b0, aclk = 1'b0, arstn = 1'b0, wp = 1'b0;
	logic [2:0] cs = 3'h0;
	logic scl, sda_low, sda, oe, sda_out, busy, we;
	logic [14:0] rd_addr, arr_addr;
	logic [7:0] arr_data;
	logic [31:0] rnd = 32'h0e49bb05;
	int error_cnt = 0, n_compared = 0, cyc = 0, wr_cnt = 0;
	always #5 clk = ~clk;
	always #24 aclk = ~aclk;
	// open drain: any party pulling wins, otherwise the pull-up; a high drive never pulls
	assign sda = !(sda_low || (oe && !sda_out));
	//==========================================================
	// instances
	bus_master_model m (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
	eeprom_bus_slave #(.DEV_CODE(CODE), .WRITE_CYCLES(WCYC)) dut (
		.i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
		.o_sda_oe(oe), .i_wp(wp), .i_chip_select_strap_0(cs[0]),
		.i_chip_select_strap_1(cs[1]), .i_chip_select_strap_2(cs[2]),
		.o_rd_addr(rd_addr), .i_rd_data(rd_fn(rd_addr)), .o_busy(busy),
		.i_array_clk(aclk), .i_array_rstn(arstn), .o_arr_we(we),
		.o_arr_addr(arr_addr), .o_arr_data(arr_data));
	always @(posedge aclk) begin
		if (we === 1'b1) wr_cnt++;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			error_cnt++;
			conclude();
		end
	end
	//==========================================================
	// helpers
	function automatic logic [7:0] rd_fn(input logic [14:0] a);
		return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h3c;
	endfunction : rd_fn
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic cmp1(input string n, input logic e, input logic s);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %b seen %b", n, e, s);
		end
	endtask : cmp1
	task automatic cmp16(input string n, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : cmp16
	task automatic conclude();
		if (error_cnt == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	// control byte, two address bytes, optional data byte; ack is 0 when all acked
	task automatic send(input logic rw, input logic [15:0] a, input logic [7:0] d,
			input logic with_data, output logic nak);
		logic [7:0] g;
		logic k;
		m.start();
		m.xfer({CODE, cs, rw}, 1'b1, g, nak);
		m.xfer(a[15:8], 1'b1, g, k);
		nak |= k;
		m.xfer(a[7:0], 1'b1, g, k);
		nak |= k;
		if (with_data) begin
			m.xfer(d, 1'b1, g, k);
			nak |= k;
		end
	endtask : send
	//==========================================================
	// scenarios
	initial begin
		logic [15:0] a;
		logic [7:0] g;
		logic k;
		int n;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		arstn <= 1'b1;
		cs <= rnd[2:0];
		repeat (4) @(posedge clk);
		for (int t = 0; t < 3; t++) begin
			rnd = lfsr(rnd);
			a = rnd[15:0];
			n = wr_cnt;
			send(1'b0, a, rnd[23:16], 1'b1, k);
			cmp1("write ack", 1'b0, k);
			m.stop();
			// a late protect level must not cancel the decided write
			if (t == 1) wp <= 1'b1;
			cmp1("busy", 1'b1, busy);
			cmp16("counter", {1'b0, a[14:0] + 15'h1}, {1'b0, rd_addr});
			for (int w = 0; w < 100 && wr_cnt == n; w++) @(posedge clk);
			cmp16("arr addr", {1'b0, a[14:0]}, {1'b0, arr_addr});
			cmp16("arr data", {8'h0, rnd[23:16]}, {8'h0, arr_data});
			m.start();
			m.xfer({CODE, cs, 1'b0}, 1'b1, g, k);
			cmp1("busy nack", 1'b1, k);
			m.stop();
			wp <= 1'b0;
			for (int w = 0; w < WCYC + 50 && busy !== 1'b0; w++) @(posedge clk);
		end
		for (int j = 1; j < 9; j++) begin
			m.start();
			m.xfer({CODE ^ {j[3], 3'h0}, cs ^ j[2:0], 1'b0}, 1'b1, g, k);
			cmp1("foreign nack", 1'b1, k);
			m.stop();
		end
		wp <= 1'b1;
		n = wr_cnt;
		send(1'b0, 16'h1234, 8'ha5, 1'b1, k);
		m.stop();
		repeat (40) @(posedge clk);
		cmp1("protected ack", 1'b0, k);
		cmp1("protected busy", 1'b0, busy);
		cmp16("protected writes", n[15:0], wr_cnt[15:0]);
		send(1'b0, 16'hffff, 8'h0, 1'b0, k);
		cmp1("protected ready", 1'b0, k);
		m.start();
		m.xfer({CODE, cs, 1'b1}, 1'b1, g, k);
		cmp1("read ack", 1'b0, k | busy);
		m.xfer(8'hff, 1'b0, g, k);
		cmp16("read 0", {8'h0, rd_fn(15'h7fff)}, {8'h0, g});
		cmp1("data out", 1'b0, sda_out);
		m.xfer(8'hff, 1'b1, g, k);
		cmp16("read wrap", {8'h0, rd_fn(15'h0)}, {8'h0, g});
		cmp1("nack release", 1'b0, oe);
		m.stop();
		cmp16("counter wrap", 16'h0001, {1'b0, rd_addr});
		wp <= 1'b0;
		m.start();
		m.bit_io(1'b1, k);
		m.bit_io(1'b0, k);
		m.bit_io(1'b1, k);
		m.start();
		m.xfer({CODE, cs, 1'b0}, 1'b1, g, k);
		cmp1("restart ack", 1'b0, k);
		m.stop();
		conclude();
	end
endmodule : testbench
`default_nettype wire
